// ===== core/akae_pkg.sv
// constants for the second-stage acl key builder and action encoder
// assumes one switch core clock domain and a frame analyzer feeding parsed fields
package akae_pkg;
    // switch geometry
    localparam int NUM_PORTS   = 11;           // front ports covered by the action port mask
    localparam int HDR_BYTES   = 82;           // frame bytes visible to custom extraction
    // ipv6 other-protocol key layout
    localparam int K_HOP_FLAG  = 44;           // hop_limit_nonzero_flag
    localparam int K_TC        = 45;           // traffic_class_byte
    localparam int K_DIP       = 53;           // ipv6_destination_addr
    localparam int K_SIP       = 181;          // ipv6_source_addr
    localparam int K_EQ_FLAG   = 309;          // addr_equal_flag
    localparam int K_NH        = 310;          // next_header_value
    localparam int K_PAYLOAD   = 318;          // post_header_bytes
    localparam int TC_W        = 8;
    localparam int ADDR_W      = 128;
    localparam int NH_W        = 8;
    localparam int PAYLOAD_W   = 56;
    localparam int IP6_KEY_W   = K_PAYLOAD + PAYLOAD_W;
    // user-defined key layout
    localparam int C_TYPE      = 44;           // extraction type selector
    localparam int C_DATA      = 45;           // extracted data field
    localparam int C_DATA_W    = 320;
    localparam int C_DATA_B    = C_DATA_W / 8;
    localparam int CUST_KEY_W  = C_DATA + C_DATA_W;
    localparam int OFS_AFTER_IP   = 34;        // extract_after_ip_header
    localparam int OFS_AFTER_SMAC = 12;        // extract_after_source_mac
    localparam int TAG_BYTES   = 4;            // one vlan tag
    localparam int MAX_TAGS    = 2;
    // action vector layout
    localparam int A_ONCE      = 0;            // copy_first_hit_only
    localparam int A_ALL       = 1;            // copy_all_hits_to_cpu
    localparam int A_QU        = 2;            // cpu_queue_select
    localparam int QU_W        = 3;
    localparam int A_MODE      = 5;            // port mask apply mode
    localparam int MODE_W      = 2;
    localparam int A_PMASK     = 20;           // action port mask
    localparam int ACT_W       = A_PMASK + NUM_PORTS;
    // port mask apply modes, in their encoded order 0..3
    typedef enum logic [MODE_W-1:0] {
        MM_NONE, MM_PERMIT, MM_POLICY, MM_REDIRECT
    } akae_mask_mode_t;
endpackage : akae_pkg

// ===== core/akae_key_build.sv
// combinational key builder: ipv6 other-protocol key and user-defined key
// assumes parsed fields and header bytes are stable while frm_valid is high
`timescale 1ns/10ps
`default_nettype none
module akae_key_build (
    // parsed ipv6 fields
    input  wire logic [7:0]                             hop_limit,
    input  wire logic [akae_pkg::TC_W-1:0]              traffic_class_byte,
    input  wire logic [akae_pkg::ADDR_W-1:0]            ipv6_destination_addr,
    input  wire logic [akae_pkg::ADDR_W-1:0]            ipv6_source_addr,
    input  wire logic [akae_pkg::NH_W-1:0]              next_header_value,
    input  wire logic [akae_pkg::PAYLOAD_W-1:0]         post_header_bytes,
    // raw header bytes, byte 0 in the low bits
    input  wire logic [akae_pkg::HDR_BYTES*8-1:0]       hdr_bytes,
    input  wire logic [1:0]                             vlan_tags,
    input  wire logic                                   custom_type,
    // keys
    output logic      [akae_pkg::IP6_KEY_W-1:0]         ip6_key,
    output logic      [akae_pkg::CUST_KEY_W-1:0]        cust_key
);
    // start byte of the custom window, skipping four bytes per vlan tag, up to two tags
    function automatic int start_ofs(input logic sel, input logic [1:0] tags);
        int base;
        int n;
        base = sel ? akae_pkg::OFS_AFTER_SMAC : akae_pkg::OFS_AFTER_IP;
        // more than two tags is clamped: the parser never strips deeper
        n = (int'(tags) > akae_pkg::MAX_TAGS) ? akae_pkg::MAX_TAGS : int'(tags);
        return base + n * akae_pkg::TAG_BYTES;
    endfunction : start_ofs

    // ipv6 key, common fields below bit 44 are filled elsewhere
    always_comb begin
        ip6_key = '0;
        ip6_key[akae_pkg::K_HOP_FLAG] = (hop_limit != 8'h00);
        ip6_key[akae_pkg::K_TC +: akae_pkg::TC_W] = traffic_class_byte;
        ip6_key[akae_pkg::K_DIP +: akae_pkg::ADDR_W] = ipv6_destination_addr;
        ip6_key[akae_pkg::K_SIP +: akae_pkg::ADDR_W] = ipv6_source_addr;
        ip6_key[akae_pkg::K_EQ_FLAG] = (ipv6_source_addr == ipv6_destination_addr);
        ip6_key[akae_pkg::K_NH +: akae_pkg::NH_W] = next_header_value;
        ip6_key[akae_pkg::K_PAYLOAD +: akae_pkg::PAYLOAD_W] = post_header_bytes;
    end

    // user-defined key, first extracted byte lands lowest in the data field
    always_comb begin
        int ofs;
        ofs = start_ofs(custom_type, vlan_tags);
        cust_key = '0;
        cust_key[akae_pkg::C_TYPE] = custom_type;
        for (int i = 0; i < akae_pkg::C_DATA_B; i++) begin
            cust_key[akae_pkg::C_DATA + i*8 +: 8] = hdr_bytes[(ofs + i)*8 +: 8];
        end
    end
endmodule : akae_key_build
`default_nettype wire

// ===== core/akae_top.sv
// second-stage acl classifier: key building and action vector application
// assumes the analyzer presents lookup one then lookup two for each frame,
// and that entry hit counters live outside and are cleared by management
`timescale 1ns/10ps
`default_nettype none
module akae_top #(
    parameter int PORTS = akae_pkg::NUM_PORTS   // ports in the action mask
) (
    // clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    // parsed frame for key building
    input  wire logic                                   frm_valid,
    input  wire logic [7:0]                             hop_limit,
    input  wire logic [akae_pkg::TC_W-1:0]              traffic_class_byte,
    input  wire logic [akae_pkg::ADDR_W-1:0]            ipv6_destination_addr,
    input  wire logic [akae_pkg::ADDR_W-1:0]            ipv6_source_addr,
    input  wire logic [akae_pkg::NH_W-1:0]              next_header_value,
    input  wire logic [akae_pkg::PAYLOAD_W-1:0]         post_header_bytes,
    input  wire logic [akae_pkg::HDR_BYTES*8-1:0]       hdr_bytes,
    input  wire logic [1:0]                             vlan_tags,
    input  wire logic                                   custom_type,
    // built keys
    output logic                                        key_valid_q,
    output logic      [akae_pkg::IP6_KEY_W-1:0]         ip6_key_q,
    output logic      [akae_pkg::CUST_KEY_W-1:0]        cust_key_q,
    // default action configuration
    input  wire logic                                   def_wr_en,
    input  wire logic [3:0]                             def_wr_port,
    input  wire logic [akae_pkg::ACT_W-1:0]             def_wr_action,
    input  wire logic [akae_pkg::ACT_W-1:0]             common_default_action,
    // lookup results
    input  wire logic                                   lkp_valid,
    input  wire logic                                   lkp_second,
    input  wire logic                                   lkp_match,
    input  wire logic [akae_pkg::ACT_W-1:0]             lkp_action,
    input  wire logic                                   lkp_entry_hit_counter_zero,
    input  wire logic [3:0]                             ingress_port,
    // forwarding contributions, sampled with the first lookup
    input  wire logic [PORTS-1:0]                       dmac_mask,
    input  wire logic [PORTS-1:0]                       filter_mask,
    input  wire logic                                   cpu_member,
    // decisions
    output logic                                        fwd_valid_q,
    output logic      [PORTS-1:0]                       fwd_mask_q,
    output logic                                        fwd_cpu_q,
    output logic                                        cpu_copy_q,
    output logic      [akae_pkg::QU_W-1:0]              cpu_queue_q,
    output logic                                        hit_inc_q,
    output logic                                        hit_inc_second_q
);
    // lookup sequencing states
    typedef enum logic {
        AKAE_WAIT_FIRST, AKAE_WAIT_SECOND
    } akae_state_t;

    akae_state_t                    state_q;        // which lookup is expected
    logic [akae_pkg::ACT_W-1:0]     def_tbl [PORTS]; // per-port default actions
    logic [akae_pkg::IP6_KEY_W-1:0] ip6_key_d;      // builder outputs
    logic [akae_pkg::CUST_KEY_W-1:0] cust_key_d;
    logic [akae_pkg::ACT_W-1:0]     act;            // effective action vector
    logic                           take;           // lookup accepted this cycle
    logic                           copy_now;       // this lookup copies to cpu
    logic                           once_now;       // copy-once fired
    logic [PORTS-1:0]               dmac_eff_q;     // running destination-mac term
    logic [PORTS-1:0]               filter_eff_q;   // running product of other terms
    logic [PORTS-1:0]               dmac_in;        // terms entering this lookup
    logic [PORTS-1:0]               filter_in;
    logic [PORTS-1:0]               dmac_out;       // terms after this lookup
    logic [PORTS-1:0]               filter_out;
    logic                           cpu_keep_q;     // cpu membership, passed through
    logic                           copy1_q;        // first lookup copied
    logic [akae_pkg::QU_W-1:0]      qu1_q;          // and its queue

    // key builder
    akae_key_build u_key (
        .hop_limit             (hop_limit),
        .traffic_class_byte    (traffic_class_byte),
        .ipv6_destination_addr (ipv6_destination_addr),
        .ipv6_source_addr      (ipv6_source_addr),
        .next_header_value     (next_header_value),
        .post_header_bytes     (post_header_bytes),
        .hdr_bytes             (hdr_bytes),
        .vlan_tags             (vlan_tags),
        .custom_type           (custom_type),
        .ip6_key               (ip6_key_d),
        .cust_key              (cust_key_d)
    );

    // register keys one cycle after the frame is offered
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            key_valid_q <= 1'b0;
            ip6_key_q   <= '0;
            cust_key_q  <= '0;
        end else begin
            key_valid_q <= frm_valid;
            if (frm_valid) begin
                ip6_key_q  <= ip6_key_d;
                cust_key_q <= cust_key_d;
            end
        end
    end

    // per-port default table; out-of-range writes are dropped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int p = 0; p < PORTS; p++) begin
                def_tbl[p] <= '0;
            end
        end else if (def_wr_en && (int'(def_wr_port) < PORTS)) begin
            def_tbl[def_wr_port] <= def_wr_action;
        end
    end

    // pick matched or default vector; downstream logic cannot tell them apart
    always_comb begin
        if (lkp_match) begin
            act = lkp_action;
        end else if (lkp_second) begin
            act = common_default_action;
        end else if (int'(ingress_port) < PORTS) begin
            act = def_tbl[ingress_port];
        end else begin
            act = '0;                    // unknown port: no action
        end
    end

    // a lookup is taken only in its own slot
    assign take = lkp_valid && (lkp_second == (state_q == AKAE_WAIT_SECOND));

    // cpu copy decisions
    assign once_now = act[akae_pkg::A_ONCE] && lkp_entry_hit_counter_zero;
    assign copy_now = once_now || act[akae_pkg::A_ALL];

    // apply one action's port mask to the running forwarding terms
    always_comb begin
        akae_pkg::akae_mask_mode_t mode;
        logic [PORTS-1:0]          pm;
        mode      = akae_pkg::akae_mask_mode_t'(act[akae_pkg::A_MODE +: akae_pkg::MODE_W]);
        pm        = act[akae_pkg::A_PMASK +: PORTS];
        dmac_in   = (state_q == AKAE_WAIT_FIRST) ? dmac_mask : dmac_eff_q;
        filter_in = (state_q == AKAE_WAIT_FIRST) ? filter_mask : filter_eff_q;
        dmac_out   = dmac_in;
        filter_out = filter_in;
        case (mode)
            akae_pkg::MM_NONE: begin
                dmac_out = dmac_in;
            end
            akae_pkg::MM_PERMIT: begin
                filter_out = filter_in & pm;
            end
            akae_pkg::MM_POLICY: begin
                dmac_out = pm;
            end
            akae_pkg::MM_REDIRECT: begin
                dmac_out   = pm;
                filter_out = '1;
            end
            default: begin
                dmac_out = dmac_in;
            end
        endcase
    end

    // lookup sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= AKAE_WAIT_FIRST;
        end else if (take) begin
            case (state_q)
                AKAE_WAIT_FIRST:  state_q <= AKAE_WAIT_SECOND;
                AKAE_WAIT_SECOND: state_q <= AKAE_WAIT_FIRST;
                default:          state_q <= AKAE_WAIT_FIRST;
            endcase
        end
    end

    // running forwarding terms and first-lookup copy state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dmac_eff_q   <= '0;
            filter_eff_q <= '0;
            cpu_keep_q   <= 1'b0;
            copy1_q      <= 1'b0;
            qu1_q        <= '0;
        end else if (take && (state_q == AKAE_WAIT_FIRST)) begin
            dmac_eff_q   <= dmac_out;
            filter_eff_q <= filter_out;
            cpu_keep_q   <= cpu_member;
            copy1_q      <= copy_now;
            qu1_q        <= act[akae_pkg::A_QU +: akae_pkg::QU_W];
        end
    end

    // final decision after the second lookup; a copying first lookup's queue wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fwd_valid_q <= 1'b0;
            fwd_mask_q  <= '0;
            fwd_cpu_q   <= 1'b0;
            cpu_copy_q  <= 1'b0;
            cpu_queue_q <= '0;
        end else begin
            fwd_valid_q <= take && (state_q == AKAE_WAIT_SECOND);
            if (take && (state_q == AKAE_WAIT_SECOND)) begin
                fwd_mask_q  <= dmac_out & filter_out;
                fwd_cpu_q   <= cpu_keep_q;
                cpu_copy_q  <= copy1_q || copy_now;
                cpu_queue_q <= copy1_q ? qu1_q
                             : act[akae_pkg::A_QU +: akae_pkg::QU_W];
            end
        end
    end

    // hit counter increment request for the entry (or default) that copied once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hit_inc_q        <= 1'b0;
            hit_inc_second_q <= 1'b0;
        end else begin
            hit_inc_q        <= take && once_now;
            hit_inc_second_q <= lkp_second;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_once_increments: assert property (take && once_now |=> hit_inc_q)
        else $error("copy-once did not request counter increment");
    // a nonzero counter must stop both the copy and a further increment
    a_once_blocked: assert property (take && !lkp_entry_hit_counter_zero && !act[akae_pkg::A_ALL]
        && state_q == AKAE_WAIT_FIRST |=> !copy1_q && !hit_inc_q)
        else $error("copy issued while hit counter nonzero");
    a_always_copy: assert property (take && state_q == AKAE_WAIT_SECOND
        && act[akae_pkg::A_ALL] |=> cpu_copy_q)
        else $error("always-copy action did not copy");
    a_queue_select: assert property (take && state_q == AKAE_WAIT_SECOND && !copy1_q
        |=> cpu_queue_q == $past(act[akae_pkg::A_QU +: akae_pkg::QU_W]))
        else $error("cpu queue not taken from action");
    a_two_lookups: assert property (fwd_valid_q |-> $past(state_q) == AKAE_WAIT_SECOND
        && state_q == AKAE_WAIT_FIRST)
        else $error("decision without two lookups");
    a_redirect_mask: assert property (take && state_q == AKAE_WAIT_SECOND
        && act[akae_pkg::A_MODE +: akae_pkg::MODE_W] == akae_pkg::MM_REDIRECT
        |=> fwd_mask_q == $past(act[akae_pkg::A_PMASK +: PORTS]))
        else $error("redirect did not replace forwarding");
    a_permit_and: assert property (take && state_q == AKAE_WAIT_SECOND
        && act[akae_pkg::A_MODE +: akae_pkg::MODE_W] == akae_pkg::MM_PERMIT
        |=> (fwd_mask_q & ~$past(act[akae_pkg::A_PMASK +: PORTS])) == '0)
        else $error("permit mode let a masked port through");
    // policy first, no action second: only the dmac term is replaced,
    // the filter term still narrows the result
    a_policy_mask: assert property (take && state_q == AKAE_WAIT_FIRST
        && act[akae_pkg::A_MODE +: akae_pkg::MODE_W] == akae_pkg::MM_POLICY
        ##1 (take && act[akae_pkg::A_MODE +: akae_pkg::MODE_W] == akae_pkg::MM_NONE)
        |=> fwd_mask_q == ($past(act[akae_pkg::A_PMASK +: PORTS], 2)
        & $past(filter_mask, 2)))
        else $error("policy mode did not replace the dmac term");
    // back-to-back pairs; spaced pairs share the same register path
    a_cpu_untouched: assert property (take && state_q == AKAE_WAIT_FIRST
        ##1 (take && state_q == AKAE_WAIT_SECOND)
        |=> fwd_cpu_q == $past(cpu_member, 2))
        else $error("cpu membership altered");
    a_common_default: assert property (lkp_valid && lkp_second && !lkp_match
        |-> act == common_default_action)
        else $error("second miss did not use common default");
    a_hop_flag: assert property (frm_valid |=> ip6_key_q[akae_pkg::K_HOP_FLAG]
        == ($past(hop_limit) != 8'h00))
        else $error("hop limit flag wrong");

    c_redirect: cover property (fwd_valid_q
        && $past(act[akae_pkg::A_MODE +: akae_pkg::MODE_W]) == akae_pkg::MM_REDIRECT);
    c_copy_once: cover property (hit_inc_q ##[1:20] fwd_valid_q && cpu_copy_q);
    c_extract_after_source_mac: cover property (frm_valid && custom_type && vlan_tags == 2'h2);
    c_port_default: cover property (take && !lkp_second && !lkp_match);
    c_once_blocked: cover property (take && act[akae_pkg::A_ONCE] && !lkp_entry_hit_counter_zero);
endmodule : akae_top
`default_nettype wire

// ===== dv/akae_hit_model.sv
// partner model: entry hit counters kept by the analyzer for both lookup slots
// assumes one entry under test per slot and a management clear pulse from the bench
`timescale 1ns/10ps
`default_nettype none
module akae_hit_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // lookup side
    input  wire logic lkp_second,
    input  wire logic hit_inc_q,
    input  wire logic hit_inc_second_q,
    input  wire logic clr,
    output logic      entry_hit_counter_zero
);
    logic [7:0] cnt_q [2];  // one counter per slot, wide enough for short runs
    // zero flag for the slot being looked up now
    assign entry_hit_counter_zero = (cnt_q[lkp_second] == 8'h00);
    // counting; clearing re-arms copy-once on the device side
    always_ff @(posedge clk) begin
        if (!rst_n || clr) begin
            cnt_q[0] <= 8'h00;
            cnt_q[1] <= 8'h00;
        end else if (hit_inc_q) begin
            cnt_q[hit_inc_second_q] <= cnt_q[hit_inc_second_q] + 8'h01;
        end
    end
endmodule : akae_hit_model
`default_nettype wire

// ===== dv/tb.sv
// testbench: key building and action application of the acl classifier block
// assumes akae_top with default geometry and the hit counter partner model
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int AW = akae_pkg::ACT_W;
    // clock, reset, design inputs and outputs
    logic clk = 0, rst_n = 0, frm_valid = 0, custom_type = 0, def_wr_en = 0;
    logic [7:0] hop_limit = 8'h00, traffic_class_byte = 8'h5c, next_header_value = 8'h3a;
    logic [127:0] ipv6_destination_addr = 128'h20010db8_00000000_00000000_0000a1b2;
    logic [127:0] ipv6_source_addr = 128'h0;
    logic [55:0] post_header_bytes = 56'h11223344556677;
    logic [akae_pkg::HDR_BYTES*8-1:0] hdr_bytes;
    logic [1:0] vlan_tags = 2'h0;
    logic [3:0] def_wr_port = 4'h0, ingress_port = 4'h0;
    logic [AW-1:0] def_wr_action = '0, common_default_action = '0, lkp_action = '0;
    logic lkp_valid = 0, lkp_second = 0, lkp_match = 0, lkp_entry_hit_counter_zero, clr = 0;
    logic [10:0] dmac_mask = 11'h0, filter_mask = 11'h0, fwd_mask_q;
    logic cpu_member = 0, key_valid_q, fwd_valid_q, fwd_cpu_q, cpu_copy_q, hit_inc_q;
    logic hit_inc_second_q;
    logic [2:0] cpu_queue_q;
    logic [akae_pkg::IP6_KEY_W-1:0] ip6_key_q;
    logic [akae_pkg::CUST_KEY_W-1:0] cust_key_q;
    int failures = 0, checked = 0;
    // clock at 40 MHz
    always #12.5 clk = ~clk;
    akae_top akae_top_inst (.clk(clk), .rst_n(rst_n), .frm_valid(frm_valid),
        .hop_limit(hop_limit), .traffic_class_byte(traffic_class_byte),
        .ipv6_destination_addr(ipv6_destination_addr), .ipv6_source_addr(ipv6_source_addr),
        .next_header_value(next_header_value), .post_header_bytes(post_header_bytes),
        .hdr_bytes(hdr_bytes), .vlan_tags(vlan_tags), .custom_type(custom_type),
        .key_valid_q(key_valid_q), .ip6_key_q(ip6_key_q), .cust_key_q(cust_key_q),
        .def_wr_en(def_wr_en), .def_wr_port(def_wr_port), .def_wr_action(def_wr_action),
        .common_default_action(common_default_action), .lkp_valid(lkp_valid),
        .lkp_second(lkp_second), .lkp_match(lkp_match), .lkp_action(lkp_action),
        .lkp_entry_hit_counter_zero(lkp_entry_hit_counter_zero), .ingress_port(ingress_port),
        .dmac_mask(dmac_mask), .filter_mask(filter_mask), .cpu_member(cpu_member),
        .fwd_valid_q(fwd_valid_q), .fwd_mask_q(fwd_mask_q), .fwd_cpu_q(fwd_cpu_q),
        .cpu_copy_q(cpu_copy_q), .cpu_queue_q(cpu_queue_q), .hit_inc_q(hit_inc_q),
        .hit_inc_second_q(hit_inc_second_q));
    akae_hit_model akae_hit_model_inst (.clk(clk), .rst_n(rst_n), .lkp_second(lkp_second),
        .hit_inc_q(hit_inc_q), .hit_inc_second_q(hit_inc_second_q), .clr(clr),
        .entry_hit_counter_zero(lkp_entry_hit_counter_zero));
    // compare and count
    task automatic check(input logic [511:0] seen, input logic [511:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    // action vector: once, all, queue, mode, port mask
    function automatic logic [AW-1:0] act(logic o, logic a, logic [2:0] q, logic [1:0] m,
                                          logic [10:0] pm);
        return {pm, 13'h0, m, q, a, o};
    endfunction : act
    // expected destination set: dmac term and filter term, both lookups in order
    function automatic logic [10:0] apply(logic [10:0] d, logic [10:0] f,
                                          logic [AW-1:0] a1, logic [AW-1:0] a2);
        logic [AW-1:0] a [2];
        a[0] = a1;
        a[1] = a2;
        for (int i = 0; i < 2; i++) begin
            case (a[i][6:5])
                2'h1: f = f & a[i][30:20];
                2'h2: d = a[i][30:20];
                2'h3: begin
                    d = a[i][30:20];
                    f = '1;
                end
                default: ;
            endcase
        end
        return d & f;
    endfunction : apply
    // one frame through the key path, then field by field
    task automatic t_key(input logic ct, input logic [1:0] tags, input logic [7:0] hop);
        int base;
        int n;
        base = ct ? 12 : 34;
        n = (tags == 2'h3) ? 2 : int'(tags);
        @(posedge clk) #1;
        frm_valid = 1;
        custom_type = ct;
        vlan_tags = tags;
        hop_limit = hop;
        ipv6_source_addr = ct ? ipv6_destination_addr : ~ipv6_destination_addr;
        @(posedge clk) #1;
        frm_valid = 0;
        check(key_valid_q, 1'b1);
        check(ip6_key_q[44], hop != 8'h00);
        check(ip6_key_q[52:45], traffic_class_byte);
        check(ip6_key_q[180:53], ipv6_destination_addr);
        check(ip6_key_q[308:181], ipv6_source_addr);
        check(ip6_key_q[309], ct);
        check(ip6_key_q[317:310], next_header_value);
        check(ip6_key_q[373:318], post_header_bytes);
        check(cust_key_q[44], ct);
        for (int i = 0; i < 40; i++)
            check(cust_key_q[45+8*i +: 8], 8'(base + 4 * n + i));
    endtask : t_key
    // two lookups back to back, then the decision; e1/e2 are the vectors in effect
    task automatic frame(input logic m1, input logic [AW-1:0] a1, e1, input logic m2,
        input logic [AW-1:0] a2, e2, input logic [3:0] port, input logic cp,
        input logic [2:0] q);
        @(posedge clk) #1;
        lkp_valid = 1;
        lkp_second = 0;
        lkp_match = m1;
        lkp_action = a1;
        ingress_port = port;
        dmac_mask = 11'h3f0;
        filter_mask = 11'h7cf;
        cpu_member = ~cpu_member;
        @(posedge clk) #1;
        check({hit_inc_q, hit_inc_second_q}, {e1[0] && cp && !e1[1], 1'b0});
        lkp_second = 1;
        lkp_match = m2;
        lkp_action = a2;
        @(posedge clk) #1;
        lkp_valid = 0;
        check(fwd_valid_q, 1'b1);
        check({hit_inc_q, hit_inc_second_q}, {e2[0], 1'b1});
        check(fwd_mask_q, apply(11'h3f0, 11'h7cf, e1, e2));
        check(fwd_cpu_q, cpu_member);
        check(cpu_copy_q, cp);
        if (cp) check(cpu_queue_q, q);
    endtask : frame
    // every mask mode on a matched first lookup, second lookup misses
    task automatic t_modes;
        logic [AW-1:0] a;
        for (int m = 0; m < 4; m++) begin
            a = act(0, 0, 3'h0, 2'(m), 11'h5a5);
            frame(1, a, a, 0, a, common_default_action, 4'h0, 0, 3'h0);
        end
    endtask : t_modes
    // misses take the per-port default, then the common default; junk vectors ignored
    task automatic t_defaults;
        logic [AW-1:0] d, j;
        d = act(0, 1, 3'h5, 2'h3, 11'h0f0);
        j = act(1, 1, 3'h7, 2'h2, 11'h7ff);
        common_default_action = act(0, 0, 3'h0, 2'h1, 11'h0cc);
        @(posedge clk) #1;
        def_wr_en = 1;
        def_wr_port = 4'h3;
        def_wr_action = d;
        @(posedge clk) #1;
        def_wr_en = 0;
        frame(0, j, d, 0, j, common_default_action, 4'h3, 1, 3'h5);
        frame(0, j, '0, 0, j, common_default_action, 4'h7, 0, 3'h0);
        common_default_action = '0;
    endtask : t_defaults
    // copy once fires, stays off, re-arms after clear; always-copy every time
    task automatic t_copy;
        logic [AW-1:0] o, z, c;
        o = act(1, 0, 3'h6, 2'h0, 11'h0);
        z = '0;
        c = act(0, 1, 3'h2, 2'h0, 11'h0);
        frame(1, o, o, 0, z, z, 4'h0, 1, 3'h6);
        frame(1, o, o, 0, z, z, 4'h0, 0, 3'h0);
        @(posedge clk) #1 clr = 1;
        @(posedge clk) #1 clr = 0;
        frame(1, o, o, 0, z, z, 4'h0, 1, 3'h6);
        frame(1, z, z, 1, c, c, 4'h0, 1, 3'h2);
        frame(1, z, z, 1, c, c, 4'h0, 1, 3'h2);
    endtask : t_copy
    // verdict and end of run
    task automatic stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    // header byte n carries value n, so any offset slip shows
    initial begin
        for (int n = 0; n < akae_pkg::HDR_BYTES; n++) hdr_bytes[8*n +: 8] = 8'(n);
        repeat (12) @(posedge clk);
        #1 rst_n = 1;
        for (int ct = 0; ct < 2; ct++)
            for (int t = 0; t < 4; t++) t_key(1'(ct), 2'(t), (t == 0) ? 8'h00 : 8'h40);
        t_modes();
        t_defaults();
        t_copy();
        stop_test();
    end
    // watchdog, far beyond the 65 or so cycles the run needs
    initial begin
        #(25 * 5000);
        failures++;
        stop_test();
    end
endmodule : tb
`default_nettype wire
